// >>> pkg/qcc_map.vh
`ifndef QCC_MAP_VH
`define QCC_MAP_VH
`define QCC_W          32
`define QCC_AW         4
`define QCC_ZERO       32'h00000000
`define QCC_ONE        32'h00000001
`define QCC_MAX        32'hFFFFFFFF
`define QCC_SCAN_DIV   16'h00FF
`define QCC_GATE_OFF_SCANS 2'h3
`define QCC_START_SCANS    2'h2
`define QCC_A_COUNT    4'h0
`define QCC_A_P1       4'h1
`define QCC_A_P2       4'h2
`define QCC_A_RELOAD   4'h3
`define QCC_A_CTRL     4'h4
`define QCC_A_STATUS   4'h5
`define QCC_B_GATE     0
`define QCC_B_OCLR     1
`define QCC_B_SWRST    2
`define QCC_B_KEEP1    3
`define QCC_B_KEEP2    4
`define QCC_B_HWEN     5
`define QCC_B_IRQSEL   6
`define QCC_B_LOAD     7
`define QCC_B_EN1      8
`define QCC_B_EN2      9
`define QCC_B_ENWRAP   10
`define QCC_CTRL_W     11
`endif

// >>> src/qcc_sync.v
`timescale 1ns/1ps
`default_nettype none
module qcc_sync (
  // clock and reset
  input  wire       mclk,
  input  wire       nrst,
  // async level in, synced out
  input  wire       d_in,
  output reg        q_out
);
  reg meta_reg;
  // two flop synchroniser
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= 1'b0;
      q_out    <= 1'b0;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// >>> src/qcc_counter.v
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "qcc_map.vh"
module qcc_counter (
  // clock and reset
  input  wire        mclk,
  input  wire        nrst,
  // encoder pins
  input  wire        phase_a_in,
  input  wire        phase_b_in,
  input  wire        index_reset_in,
  input  wire        gen_reset_in,
  // register port
  input  wire [3:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  // outputs
  output reg         cmp1_out,
  output reg         cmp2_out,
  output reg         irq_jump,
  output reg         count_enabled
);
  wire a_s;
  wire b_s;
  wire z_s;
  wire g_s;
  reg  b_d_reg;
  reg  z_d_reg;
  reg  g_d_reg;
  reg  [31:0] cnt_reg;
  reg  [31:0] count_value;
  reg  [31:0] preset_one;
  reg  [31:0] preset_two;
  reg  [31:0] act_one;
  reg  [31:0] act_two;
  reg  [31:0] reload_value;
  reg  [`QCC_CTRL_W-1:0] ctrl_reg;
  reg  [15:0] div_reg;
  reg         scan_tick;
  reg  [1:0]  start_reg;
  reg         armed_reg;
  reg         blocked_reg;
  reg  [1:0]  goff_reg;
  reg         ev1_reg;
  reg         ev2_reg;
  reg         evw_reg;
  reg         evz_reg;
  reg         cmp1_hit_flag;
  reg         cmp2_hit_flag;
  reg         wrap_flag;
  reg         reset_seen_flag;
  reg         pend1_reg;
  reg         pend2_reg;
  reg  [31:0] cnt_next;
  reg         hit1;
  reg         hit2;
  reg         wrap;
  reg         zrise;
  wire        gate_enable_flag;
  wire        step;
  wire        up;

  // pin synchronisers
  qcc_sync u_sa (.mclk(mclk), .nrst(nrst), .d_in(phase_a_in),
                 .q_out(a_s));
  qcc_sync u_sb (.mclk(mclk), .nrst(nrst), .d_in(phase_b_in),
                 .q_out(b_s));
  qcc_sync u_sz (.mclk(mclk), .nrst(nrst), .d_in(index_reset_in),
                 .q_out(z_s));
  qcc_sync u_sg (.mclk(mclk), .nrst(nrst), .d_in(gen_reset_in),
                 .q_out(g_s));

  assign gate_enable_flag = ctrl_reg[`QCC_B_GATE];
  // 1-edge count on rising phase b, direction from phase a
  assign step = b_s & ~b_d_reg & gate_enable_flag & armed_reg &
                ~blocked_reg;
  assign up   = a_s;

  // scan divider
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_reg   <= 16'h0000;
      scan_tick <= 1'b0;
    end else begin
      scan_tick <= (div_reg == `QCC_SCAN_DIV);
      if (div_reg == `QCC_SCAN_DIV)
        div_reg <= 16'h0000;
      else
        div_reg <= div_reg + 16'h0001;
    end
  end

  // next count and comparison detect
  always @* begin
    hit1     = 1'b0;
    hit2     = 1'b0;
    wrap     = 1'b0;
    zrise    = z_s & ~z_d_reg & ctrl_reg[`QCC_B_HWEN];
    cnt_next = cnt_reg;
    if (step) begin
      if (up) begin
        cnt_next = cnt_reg + `QCC_ONE;
        wrap     = (cnt_reg == `QCC_MAX);
      end else begin
        cnt_next = cnt_reg - `QCC_ONE;
        wrap     = (cnt_reg == `QCC_ZERO);
      end
      hit1 = ctrl_reg[`QCC_B_EN1] & (cnt_next == act_one);
      hit2 = ctrl_reg[`QCC_B_EN2] & (cnt_next == act_two);
      if (wrap)
        cnt_next = reload_value;
      else if ((hit1 & ~ctrl_reg[`QCC_B_KEEP1]) |
               (hit2 & ~ctrl_reg[`QCC_B_KEEP2]))
        cnt_next = reload_value;
    end
    if (zrise | (g_s & ~g_d_reg) | ctrl_reg[`QCC_B_SWRST])
      cnt_next = reload_value;
  end

  // counting core
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= `QCC_ZERO; b_d_reg <= 1'b0; z_d_reg <= 1'b0;
      g_d_reg <= 1'b0;
      act_one <= `QCC_ZERO; act_two <= `QCC_ZERO;
      pend1_reg <= 1'b0; pend2_reg <= 1'b0;
      ev1_reg <= 1'b0; ev2_reg <= 1'b0; evw_reg <= 1'b0; evz_reg <= 1'b0;
      cmp1_out <= 1'b0; cmp2_out <= 1'b0; irq_jump <= 1'b0;
    end else begin
      b_d_reg <= b_s;
      z_d_reg <= z_s;
      g_d_reg <= g_s;
      irq_jump <= 1'b0;
      if (!armed_reg || (wr && addr == `QCC_A_CTRL &&
                         wdata[`QCC_B_LOAD]))
        cnt_reg <= reload_value;
      else
        cnt_reg <= cnt_next;
      // active presets swap when old one reached, on an index reset, or at arming
      if (start_reg == `QCC_START_SCANS && scan_tick && !armed_reg) begin
        act_one <= preset_one;
        act_two <= preset_two;
      end else begin
        if ((hit1 || zrise) && pend1_reg)
          act_one <= preset_one;
        if ((hit2 || zrise) && pend2_reg)
          act_two <= preset_two;
      end
      if (wr && addr == `QCC_A_P1)
        pend1_reg <= 1'b1;
      else if (hit1 || zrise)
        pend1_reg <= 1'b0;
      if (wr && addr == `QCC_A_P2)
        pend2_reg <= 1'b1;
      else if (hit2 || zrise)
        pend2_reg <= 1'b0;
      // events held until the next scan boundary, set wins
      ev1_reg <= hit1 | (ev1_reg & ~scan_tick);
      ev2_reg <= hit2 | (ev2_reg & ~scan_tick);
      evw_reg <= wrap | (evw_reg & ~scan_tick);
      evz_reg <= zrise | (evz_reg & ~scan_tick);
      // action: output latch or interrupt jump; clear works in either mode
      if (ctrl_reg[`QCC_B_IRQSEL] &&
          (hit1 | hit2 | (wrap & ctrl_reg[`QCC_B_ENWRAP])))
        irq_jump <= 1'b1;
      if (!ctrl_reg[`QCC_B_IRQSEL] &&
          (hit1 | (wrap & ctrl_reg[`QCC_B_ENWRAP])))
        cmp1_out <= 1'b1;
      else if (ctrl_reg[`QCC_B_OCLR])
        cmp1_out <= 1'b0;
      if (!ctrl_reg[`QCC_B_IRQSEL] &&
          (hit2 | (wrap & ctrl_reg[`QCC_B_ENWRAP])))
        cmp2_out <= 1'b1;
      else if (ctrl_reg[`QCC_B_OCLR])
        cmp2_out <= 1'b0;
    end
  end

  // scan state: start-up, visible copy, one-scan flags, gate lockout
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      start_reg <= 2'h0; armed_reg <= 1'b0; blocked_reg <= 1'b0;
      goff_reg <= 2'h0; count_value <= `QCC_ZERO;
      cmp1_hit_flag <= 1'b0; cmp2_hit_flag <= 1'b0; wrap_flag <= 1'b0;
      reset_seen_flag <= 1'b0; count_enabled <= 1'b0;
    end else begin
      count_enabled <= gate_enable_flag & armed_reg & ~blocked_reg;
      if (wr && addr == `QCC_A_CTRL && wdata[`QCC_B_LOAD]) begin
        blocked_reg <= gate_enable_flag;
        goff_reg    <= 2'h0;
      end else if (scan_tick) begin
        if (start_reg != `QCC_START_SCANS)
          start_reg <= start_reg + 2'h1;
        else
          armed_reg <= 1'b1;
        count_value   <= cnt_reg;
        cmp1_hit_flag <= ev1_reg;
        cmp2_hit_flag <= ev2_reg;
        wrap_flag     <= evw_reg;
        reset_seen_flag <= evz_reg;
        if (gate_enable_flag) begin
          if (goff_reg == `QCC_GATE_OFF_SCANS)
            blocked_reg <= 1'b0;
          goff_reg <= 2'h0;
        end else if (goff_reg != `QCC_GATE_OFF_SCANS)
          goff_reg <= goff_reg + 2'h1;
      end
    end
  end

  // register writes
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      preset_one <= `QCC_ZERO; preset_two <= `QCC_ZERO;
      reload_value <= `QCC_ZERO; ctrl_reg <= {`QCC_CTRL_W{1'b0}};
    end else if (wr) begin
      case (addr)
        `QCC_A_P1:     preset_one   <= wdata;
        `QCC_A_P2:     preset_two   <= wdata;
        `QCC_A_RELOAD: reload_value <= wdata;
        `QCC_A_CTRL: begin
          ctrl_reg <= wdata[`QCC_CTRL_W-1:0];
          ctrl_reg[`QCC_B_LOAD] <= 1'b0;
        end
        default: ;
      endcase
    end else begin
      ctrl_reg[`QCC_B_SWRST] <= 1'b0;
    end
  end

  // register reads, one cycle later
  always @(posedge mclk or negedge nrst) begin
    if (!nrst)
      rdata <= `QCC_ZERO;
    else if (rd) begin
      case (addr)
        `QCC_A_COUNT:  rdata <= count_value;
        `QCC_A_P1:     rdata <= preset_one;
        `QCC_A_P2:     rdata <= preset_two;
        `QCC_A_RELOAD: rdata <= reload_value;
        `QCC_A_CTRL:   rdata <= {21'h0, ctrl_reg};
        `QCC_A_STATUS: rdata <= {26'h0, count_enabled, armed_reg,
                                 reset_seen_flag, wrap_flag,
                                 cmp2_hit_flag, cmp1_hit_flag};
        default:       rdata <= `QCC_ZERO;
      endcase
    end else
      rdata <= `QCC_ZERO;
  end
endmodule
`default_nettype wire

// >>> tb/qcc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module qcc_assertions (
  // clock and reset
  input wire        mclk,
  input wire        nrst,
  // register port
  input wire [3:0]  addr,
  input wire [31:0] wdata,
  input wire        wr,
  input wire        rd,
  input wire [31:0] rdata,
  // outputs
  input wire        cmp1_out,
  input wire        cmp2_out,
  input wire        irq_jump,
  input wire        count_enabled
);
  // mirror of the control word, cycles since reset
  reg [10:0] ctl_reg;
  reg [11:0] cyc_reg;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctl_reg <= 11'h000;
      cyc_reg <= 12'h000;
    end else begin
      if (wr && addr == 4'h4) ctl_reg <= wdata[10:0];
      if (cyc_reg != 12'hFFF) cyc_reg <= cyc_reg + 12'h001;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_rd_idle; !$past(rd) |-> rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its slot");
  property p_hold1; cmp1_out && !ctl_reg[1] |=> cmp1_out; endproperty
  a_hold1: assert property (p_hold1)
    else $error("output one dropped without clear");
  property p_hold2; cmp2_out && !ctl_reg[1] |=> cmp2_out; endproperty
  a_hold2: assert property (p_hold2)
    else $error("output two dropped without clear");
  property p_irq_pulse; irq_jump |=> !irq_jump; endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("jump request longer than one cycle");
  property p_irq_sel; irq_jump |-> ctl_reg[6]; endproperty
  a_irq_sel: assert property (p_irq_sel)
    else $error("jump request in output mode");
  property p_out_sel; $rose(cmp1_out) |-> !ctl_reg[6]; endproperty
  a_out_sel: assert property (p_out_sel)
    else $error("output set in jump mode");
  property p_gate; (!ctl_reg[0]) [*3] |-> !count_enabled; endproperty
  a_gate: assert property (p_gate)
    else $error("counting with gate off");
  property p_start; cyc_reg < 12'h200 |-> !count_enabled; endproperty
  a_start: assert property (p_start)
    else $error("counting before start-up scans");
  property p_load;
    wr && addr == 4'h4 && wdata[7] && ctl_reg[0]
      |-> ##3 (!count_enabled) [*8];
  endproperty
  a_load: assert property (p_load)
    else $error("counting after load with gate on");
endmodule
bind qcc_counter qcc_assertions u_chk (.mclk(mclk), .nrst(nrst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .cmp1_out(cmp1_out), .cmp2_out(cmp2_out), .irq_jump(irq_jump),
  .count_enabled(count_enabled));
`default_nettype wire

// >>> tb/qcc_encoder.sv
`timescale 1ns/1ps
`default_nettype none
module qcc_encoder (
  // pacing clock
  input  wire mclk,
  // encoder lines
  output logic phase_a,
  output logic phase_b,
  output logic index
);
  // lines rest low
  initial begin
    phase_a = 1'b0;
    phase_b = 1'b0;
    index = 1'b0;
  end
  // n detents, four phase changes each, gap cycles apart
  task automatic move(input int n, input bit up, input int gap);
    int i;
    int j;
    for (i = 0; i < 4 * n; i++) begin
      j = i % 4;
      repeat (gap) @(posedge mclk);
      // a leads b going up, trails it going down
      if ((j[0] == 1'b0) == up) phase_a <= ~phase_a;
      else phase_b <= ~phase_b;
    end
  endtask
  // index pulse of gap cycles
  task automatic pulse(input int gap);
    @(posedge mclk);
    index <= 1'b1;
    repeat (gap) @(posedge mclk);
    index <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// compare, count, report a miss
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        gen_rst = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rv;
  logic [31:0] cv;
  logic [31:0] rld;
  wire logic [31:0] rdata;
  wire logic   pa, pb, idx, c1, c2, irq, cen;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          n_irq = 0;
  int          cycles = 0;
  int          seed = 32'h6921;
  // encoder partner and device
  qcc_encoder u_enc (.mclk(mclk), .phase_a(pa), .phase_b(pb), .index(idx));
  qcc_counter u_dut (.mclk(mclk), .nrst(nrst), .phase_a_in(pa),
    .phase_b_in(pb), .index_reset_in(idx), .gen_reset_in(gen_rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cmp1_out(c1), .cmp2_out(c2), .irq_jump(irq), .count_enabled(cen));
  always #20 mclk = ~mclk;
  // jump requests seen, hang guard
  always @(posedge mclk) begin
    cycles++;
    if (irq === 1'b1) n_irq++;
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // next count for one detent; a wrap reloads
  function logic [31:0] stepv(input logic [31:0] c, input bit up);
    if (up && c == 32'hFFFFFFFF) return rld;
    if (!up && c == 32'h0) return rld;
    return up ? c + 32'h1 : c - 32'h1;
  endfunction
  task mv(input int n, input bit up, input bit on);
    int i;
    for (i = 0; i < n; i++) begin
      u_enc.move(1, up, 4 + {$random(seed)} % 8);
      if (on) cv = stepv(cv, up);
    end
  endtask
  // wait past a scan, read the count copy
  task cnt_is(input logic [31:0] e);
    repeat (300) @(posedge mclk);
    rreg(4'h0, rv);
    `CHK("count", e, rv)
  endtask
  task grst();
    gen_rst <= 1'b1;
    repeat (6) @(posedge mclk);
    gen_rst <= 1'b0;
    cv = rld;
  endtask
  initial begin
    rld = $random(seed) & 32'h0000FFFF;
    cv = rld;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    wreg(4'h3, rld);
    wreg(4'h1, rld + 32'h5);
    wreg(4'h2, rld + 32'h9);
    wreg(4'h4, 32'h00000309);
    repeat (900) @(posedge mclk);
    `CHK("enabled", 1'b1, cen)
    cnt_is(cv);
    mv(3, 1, 1);
    mv(1, 0, 1);
    cnt_is(cv);
    mv(3, 1, 1);
    cnt_is(cv);
    `CHK("cmp1", 1'b1, c1)
    mv(4, 1, 1);
    cv = rld;
    cnt_is(cv);
    `CHK("cmp2", 1'b1, c2)
    mv(1, 1, 1);
    cnt_is(cv);
    wreg(4'h4, 32'h00000308);
    mv(2, 1, 0);
    cnt_is(cv);
    $display("counting and presets done");
    wreg(4'h4, 32'h0000030B);
    repeat (8) @(posedge mclk);
    `CHK("cmp1 clear", 1'b0, c1)
    `CHK("cmp2 clear", 1'b0, c2)
    wreg(4'h4, 32'h00000309);
    mv(2, 1, 1);
    u_enc.pulse(6);
    cnt_is(cv);
    wreg(4'h4, 32'h00000329);
    u_enc.pulse(6);
    cv = rld;
    cnt_is(cv);
    mv(2, 1, 1);
    grst();
    cnt_is(cv);
    $display("reloads done");
    rld = 32'hFFFFFFFE;
    wreg(4'h3, rld);
    wreg(4'h4, 32'h00000709);
    grst();
    mv(2, 1, 1);
    cnt_is(cv);
    `CHK("wrap out", 1'b1, c1)
    wreg(4'h4, 32'h0000074B);
    wreg(4'h4, 32'h00000749);
    mv(2, 1, 1);
    cnt_is(cv);
    `CHK("jumps", 1, n_irq)
    `CHK("jump out", 1'b0, c1)
    rreg(4'hF, rv);
    `CHK("unmapped", 32'h0, rv)
    $display("wrap and jump done");
    wreg(4'h4, 32'h000007C9);
    repeat (8) @(posedge mclk);
    `CHK("blocked", 1'b0, cen)
    mv(1, 1, 0);
    cnt_is(cv);
    wreg(4'h4, 32'h00000748);
    repeat (1000) @(posedge mclk);
    wreg(4'h4, 32'h00000749);
    repeat (600) @(posedge mclk);
    `CHK("resumed", 1'b1, cen)
    $display("load block done");
    give_verdict();
  end
endmodule
`default_nettype wire
